// *** design/pts_map.svh ***
// Overview of operation
// - Even parity per bit over previous frame, compared to current parity byte.
// - Any parity difference marks the frame errored and counts a near errored block.
// - Recover sixteen-byte trace identifier; present the accepted one to management.
// - Accept trace, compare with expected one; mismatch detection can be disabled.
// - Maintenance byte bit 1 is remote defect, bit 2 is remote error.
// - Remote defect bit one means remote defect state, zero means normal.
// - Remote error bit counts far-end errored blocks of reverse direction.
// - Signal label bits three to five detect an unequipped path.
// - Detect and clear unequipped, degraded, remote defect, mismatch by persistence.
// - Server fail, unequipped or mismatch raise fail and remote defect; degrade; error count.
// - Unequipped or mismatch replace output data by all ones within 250 us.
// - Unequipped cause needs monitoring; mismatch cause needs monitoring and not unequipped.
// - Degraded cause needs monitoring, degrade, no unequipped, no mismatch.
// - Remote defect cause also needs no mismatch, no unequipped, reporting enabled.
// - Server fail cause needs monitoring, server fail, reporting enabled; default off.
// - Per second flag near and far defect seconds; sum near and far errored blocks.
`ifndef PTS_MAP_SVH
`define PTS_MAP_SVH
`define PTS_CTRL_OFS 8'h00
`define PTS_DEG_OFS 8'h04
`define PTS_STAT_OFS 8'h08
`define PTS_IST_OFS 8'h0c
`define PTS_IMASK_OFS 8'h10
`define PTS_NEBC_OFS 8'h14
`define PTS_FEBC_OFS 8'h18
`define PTS_SEC_OFS 8'h1c
`define PTS_EXP_OFS 8'h20
`define PTS_ACC_OFS 8'h30
`define PTS_CTRL_RST 4'h0
`define PTS_DEG_THR_RST 16'h0010
`define PTS_DEG_M_RST 4'h2
`define PTS_EM_POS 10'h002
`define PTS_TR_POS 10'h003
`define PTS_MA_POS 10'h004
`define PTS_RDI_BIT 7
`define PTS_REI_BIT 6
`define PTS_PERSIST 3'h5
`define PTS_TTI_SAME 2'h3
`define PTS_CLK_NS 4
`define PTS_AIS_LIMIT_US 250
`define PTS_AIS_LIMIT_CYC ((`PTS_AIS_LIMIT_US * 1000) / `PTS_CLK_NS)
`define PTS_ONE_SEC_US 1000000
`define PTS_ONE_SEC_CYC ((`PTS_ONE_SEC_US * 1000) / `PTS_CLK_NS)
`endif

// *** design/pts_pkg.sv ***
package pts_pkg;
    // Management controls, bit 3 downward
    typedef struct packed {
        logic tim_dis;
        logic rdi_rep;
        logic ssf_rep;
        logic monitored;
    } pts_ctrl_t;
    // Fault causes, unequipped in bit 0
    typedef struct packed {
        logic ssf;
        logic rdi;
        logic deg;
        logic tim;
        logic uneq;
    } pts_cause_t;
    // Inputs from outside the clock domain
    typedef struct packed {
        logic ck;
        logic d;
        logic fs;
        logic ssf;
        logic eq;
    } pts_pins_t;
    typedef enum logic {PTS_TTI_HUNT, PTS_TTI_LOCK} pts_tti_t;
endpackage : pts_pkg

// *** design/pts_trail_sink.sv ***
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pts_map.svh"
module pts_trail_sink #(
    parameter int unsigned ONE_SEC_CYCLES = `PTS_ONE_SEC_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic link_fs,
    input wire logic server_signal_fail_in,
    input wire logic equipment_defect,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic data_out,
    output logic clk_out,
    output logic fs_out,
    output logic trail_signal_fail_out,
    output logic trail_signal_degrade_out,
    output logic remote_defect_request,
    output logic [3:0] remote_error_request,
    output logic remote_error_valid,
    output logic irq
);
    typedef struct packed {
        // Synchronisers and bit alignment
        pts_pkg::pts_pins_t s1;
        pts_pkg::pts_pins_t s2;
        logic ck_d;
        logic [7:0] sh;
        logic [2:0] bit_i;
        logic [9:0] byte_i;
        logic framed;
        logic [7:0] bip_acc;
        logic [7:0] bip_prev;
        logic bip_ok;

        // Trace recovery and acceptance
        logic [15:0][7:0] tti_rx;
        logic [15:0][7:0] tti_last;
        logic [15:0][7:0] tti_acc;
        logic [15:0][7:0] tti_exp;
        logic [3:0] tti_i;
        logic [1:0] tti_same;
        pts_pkg::pts_tti_t tti_st;

        // Defect filters
        logic [2:0] uneq_run;
        logic [2:0] rdi_run;
        logic uneq;
        logic rdi;
        logic tim;
        logic deg;
        logic [3:0] deg_run;

        // One-second window
        logic [31:0] sec_cnt;
        logic [15:0] nacc;
        logic [15:0] facc;
        logic nds_acc;
        logic fds_acc;
        logic [15:0] nebc;
        logic [15:0] febc;
        logic nds;
        logic fds;

        // Management settings
        pts_pkg::pts_ctrl_t ctrl;
        logic [15:0] deg_thr;
        logic [3:0] deg_m;
        pts_pkg::pts_cause_t cause;
        logic [5:0] ist;
        logic [5:0] imask;

        // Registered outputs
        logic d_o;
        logic ck_o;
        logic fs_o;
        logic tsf;
        logic tsd;
        logic rdi_req;
        logic [3:0] rei;
        logic rei_v;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pts_state_t;

    pts_state_t r_reg;
    pts_state_t r_next;

    // Persistence filter: defect toggles after five frames of the opposite condition
    function automatic logic [3:0] pts_persist(input logic cond, input logic def, input logic [2:0] run);
        logic [2:0] nrun;
        nrun = run + 3'h1;
        if (cond == def)
            pts_persist = {def, 3'h0};
        else if (nrun == `PTS_PERSIST)
            pts_persist = {cond, 3'h0};
        else
            pts_persist = {def, nrun};
    endfunction : pts_persist

    // Number of differing parity bits in one byte
    function automatic logic [3:0] pts_ones(input logic [7:0] v);
        pts_ones = 4'h0;
        for (int i = 0; i < 8; i++)
            pts_ones = pts_ones + {3'h0, v[i]};
    endfunction : pts_ones

    // Helpers, recomputed every cycle
    logic edge_ck;
    logic [2:0] cur_bit;
    logic [9:0] cur_byte;
    logic [7:0] byte_v;
    logic byte_done;

    logic sec_tick;
    logic mon;
    logic ais;
    logic bad_sec;
    logic [3:0] deg_lim;
    logic [3:0] pf;
    logic [3:0] viol;

    logic wr;
    logic [5:0] ev;
    logic [31:0] rd;

    always_comb
    begin
        r_next = r_reg;
        viol = 4'h0;
        rd = 32'h0;
        pf = 4'h0;
        // Two-stage synchronisers; stage one feeds only stage two
        // Data shares the clock's path, so bit and edge agree
        r_next.s1 = '{ck: link_clk, d: link_data, fs: link_fs, ssf: server_signal_fail_in, eq: equipment_defect};
        r_next.s2 = r_reg.s1;
        r_next.ck_d = r_reg.s2.ck;
        edge_ck = r_reg.s2.ck & ~r_reg.ck_d;
        cur_bit = r_reg.s2.fs ? 3'h0 : r_reg.bit_i;
        cur_byte = r_reg.s2.fs ? 10'h000 : r_reg.byte_i;
        byte_v = {r_reg.sh[6:0], r_reg.s2.d};
        byte_done = edge_ck && (r_reg.framed || r_reg.s2.fs) && cur_bit == 3'h7;
        r_next.rei_v = 1'b0;

        // Bit and byte alignment restarts at every frame start
        if (edge_ck)
        begin
            r_next.sh = byte_v;
            r_next.bit_i = cur_bit + 3'h1;
            if (r_reg.s2.fs)
            begin
                r_next.framed = 1'b1;
                r_next.bip_prev = r_reg.bip_acc;
                r_next.bip_ok = r_reg.framed;
                r_next.bip_acc = 8'h00;
                r_next.byte_i = 10'h000;
            end
        end

        if (byte_done)
        begin
            r_next.byte_i = cur_byte + 10'h001;
            // Parity covers every byte, overhead included
            r_next.bip_acc = r_next.bip_acc ^ byte_v;
            // First frame has nothing to compare against
            if (cur_byte == `PTS_EM_POS && r_reg.bip_ok)
            begin
                viol = pts_ones(byte_v ^ r_reg.bip_prev);
                r_next.rei = viol;
                r_next.rei_v = 1'b1;
                if (viol != 4'h0 && r_reg.nacc != 16'hffff)
                    r_next.nacc = r_reg.nacc + 16'h0001;
            end

            // Remote defect and unequipped filtered per frame; remote error counted unfiltered
            if (cur_byte == `PTS_MA_POS)
            begin
                pf = pts_persist(byte_v[`PTS_RDI_BIT], r_reg.rdi, r_reg.rdi_run);
                r_next.rdi = pf[3];
                r_next.rdi_run = pf[2:0];
                pf = pts_persist(byte_v[5:3] == 3'h0, r_reg.uneq, r_reg.uneq_run);
                r_next.uneq = pf[3];
                r_next.uneq_run = pf[2:0];
                if (byte_v[`PTS_REI_BIT] && r_reg.facc != 16'hffff)
                    r_next.facc = r_reg.facc + 16'h0001;
            end

            // Trace multiframe: first byte has its top bit set, the others clear
            if (cur_byte == `PTS_TR_POS)
            begin
                case (r_reg.tti_st)
                    pts_pkg::PTS_TTI_HUNT:
                    begin
                        if (byte_v[7])
                        begin
                            r_next.tti_rx[0] = byte_v;
                            r_next.tti_i = 4'h1;
                            r_next.tti_st = pts_pkg::PTS_TTI_LOCK;
                        end
                    end
                    pts_pkg::PTS_TTI_LOCK:
                    begin
                        r_next.tti_rx[r_reg.tti_i] = byte_v;
                        r_next.tti_i = r_reg.tti_i + 4'h1;
                        if (byte_v[7] != (r_reg.tti_i == 4'h0))
                        begin
                            r_next.tti_st = pts_pkg::PTS_TTI_HUNT;
                            r_next.tti_same = 2'h0;
                        end
                        else if (r_reg.tti_i == 4'hf)
                        begin
                            // Accept only after three identical identifiers in a row
                            r_next.tti_last = r_next.tti_rx;
                            if (r_next.tti_rx != r_reg.tti_last)
                                r_next.tti_same = 2'h1;
                            else if (r_reg.tti_same != `PTS_TTI_SAME)
                                r_next.tti_same = r_reg.tti_same + 2'h1;
                            if (r_next.tti_rx == r_reg.tti_last && r_reg.tti_same == `PTS_TTI_SAME - 2'h1)
                                r_next.tti_acc = r_next.tti_rx;
                        end
                    end
                    default:
                        r_next.tti_st = pts_pkg::PTS_TTI_HUNT;
                endcase
            end
        end

        // Mismatch compares accepted with expected unless disabled
        // Disabling drops the defect at once
        r_next.tim = ~r_reg.ctrl.tim_dis && (r_reg.tti_acc != r_reg.tti_exp);

        // One-second window for degrade and performance figures
        sec_tick = r_reg.sec_cnt == ONE_SEC_CYCLES - 1;
        r_next.sec_cnt = sec_tick ? 32'h0 : r_reg.sec_cnt + 32'h1;
        r_next.nds_acc = r_reg.nds_acc | r_reg.tsf | r_reg.s2.eq;
        r_next.fds_acc = r_reg.fds_acc | r_reg.rdi;
        bad_sec = r_reg.nacc > r_reg.deg_thr;
        deg_lim = (r_reg.deg_m == 4'h0) ? 4'h1 : r_reg.deg_m;
        // Counters restart on the tick
        if (sec_tick)
        begin
            r_next.nebc = r_reg.nacc;
            r_next.febc = r_reg.facc;
            r_next.nds = r_reg.nds_acc;
            r_next.fds = r_reg.fds_acc;
            r_next.nacc = 16'h0;
            r_next.facc = 16'h0;
            r_next.nds_acc = 1'b0;
            r_next.fds_acc = 1'b0;

            // Degrade sets after so many bad seconds and clears after as many good ones
            if (bad_sec != r_reg.deg)
            begin
                r_next.deg_run = r_reg.deg_run + 4'h1;
                if (r_reg.deg_run + 4'h1 >= deg_lim)
                begin
                    r_next.deg = bad_sec;
                    r_next.deg_run = 4'h0;
                end
            end
            else
                r_next.deg_run = 4'h0;
        end

        // Consequent actions and correlations
        // Causes lag defects one cycle; harmless for polling
        mon = r_reg.ctrl.monitored;
        ais = r_reg.uneq | r_reg.tim;
        r_next.tsf = r_reg.s2.ssf | ais;
        r_next.rdi_req = r_reg.s2.ssf | ais;
        r_next.tsd = r_reg.deg;
        r_next.cause.uneq = mon & r_reg.uneq;
        r_next.cause.tim = mon & r_reg.tim & ~r_reg.uneq;
        r_next.cause.deg = mon & r_reg.deg & ~r_reg.uneq & ~r_reg.tim;
        r_next.cause.rdi = mon & r_reg.rdi & ~r_reg.tim & ~r_reg.uneq & r_reg.ctrl.rdi_rep;
        r_next.cause.ssf = mon & r_reg.s2.ssf & r_reg.ctrl.ssf_rep;

        // Pass-through with a fixed three-cycle latency on all three lines
        r_next.d_o = ais | r_reg.s2.d;
        r_next.ck_o = r_reg.s2.ck;
        r_next.fs_o = r_reg.s2.fs;

        // APB: answer in the access cycle, data prepared during setup
        wr = psel & penable & r_reg.pready & pwrite;
        r_next.pready = psel & ~penable;
        r_next.pslverr = psel & ~penable & (paddr[7:6] != 2'h0 || paddr[1:0] != 2'h0);
        case (paddr)
            `PTS_CTRL_OFS: rd = {28'h0, r_reg.ctrl};
            `PTS_DEG_OFS: rd = {12'h0, r_reg.deg_m, r_reg.deg_thr};
            `PTS_STAT_OFS: rd = {21'h0, r_reg.tti_st == pts_pkg::PTS_TTI_LOCK, r_reg.cause,
                                 r_reg.s2.ssf, r_reg.rdi, r_reg.deg, r_reg.tim, r_reg.uneq};
            `PTS_IST_OFS: rd = {26'h0, r_reg.ist};
            `PTS_IMASK_OFS: rd = {26'h0, r_reg.imask};
            `PTS_NEBC_OFS: rd = {16'h0, r_reg.nebc};
            `PTS_FEBC_OFS: rd = {16'h0, r_reg.febc};
            `PTS_SEC_OFS: rd = {30'h0, r_reg.fds, r_reg.nds};
            default:
            begin
                for (int k = 0; k < 4; k++)
                begin
                    if (paddr == `PTS_EXP_OFS + 8'(4 * k))
                        rd = {r_reg.tti_exp[4*k+3], r_reg.tti_exp[4*k+2], r_reg.tti_exp[4*k+1], r_reg.tti_exp[4*k]};
                    if (paddr == `PTS_ACC_OFS + 8'(4 * k))
                        rd = {r_reg.tti_acc[4*k+3], r_reg.tti_acc[4*k+2], r_reg.tti_acc[4*k+1], r_reg.tti_acc[4*k]};
                end
            end
        endcase

        // Latched in setup, stands in access
        if (psel & ~penable & ~pwrite)
            r_next.prdata = rd;

        // Writes land at the access edge only
        if (wr && paddr == `PTS_CTRL_OFS)
            r_next.ctrl = pwdata[3:0];
        if (wr && paddr == `PTS_DEG_OFS)
        begin
            r_next.deg_thr = pwdata[15:0];
            r_next.deg_m = pwdata[19:16];
        end
        if (wr && paddr == `PTS_IMASK_OFS)
            r_next.imask = pwdata[5:0];
        for (int k = 0; k < 4; k++)
        begin
            if (wr && paddr == `PTS_EXP_OFS + 8'(4 * k))
                {r_next.tti_exp[4*k+3], r_next.tti_exp[4*k+2], r_next.tti_exp[4*k+1], r_next.tti_exp[4*k]} = pwdata;
        end

        // Sticky events on cause rising edges and the one-second tick; a new event beats a same-cycle clear
        ev = {sec_tick, r_next.cause & ~r_reg.cause};
        r_next.ist = (r_reg.ist & ~((wr && paddr == `PTS_IST_OFS) ? pwdata[5:0] : 6'h0)) | ev;
        r_next.irq = |(r_next.ist & r_next.imask);
    end

    // Single state register; reset gives constants only
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg <= '0;
            r_reg.ctrl <= `PTS_CTRL_RST;
            r_reg.deg_thr <= `PTS_DEG_THR_RST;
            r_reg.deg_m <= `PTS_DEG_M_RST;
            r_reg.tti_st <= pts_pkg::PTS_TTI_HUNT;
        end
        else
            r_reg <= r_next;
    end

    // Pins straight from the state register
    assign prdata = r_reg.prdata;
    assign pready = r_reg.pready;
    assign pslverr = r_reg.pslverr;
    assign data_out = r_reg.d_o;
    assign clk_out = r_reg.ck_o;
    assign fs_out = r_reg.fs_o;
    assign trail_signal_fail_out = r_reg.tsf;
    assign trail_signal_degrade_out = r_reg.tsd;
    assign remote_defect_request = r_reg.rdi_req;
    assign remote_error_request = r_reg.rei;
    assign remote_error_valid = r_reg.rei_v;
    assign irq = r_reg.irq;
endmodule : pts_trail_sink
`default_nettype wire

// *** tb/pts_trail_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// Pin-level watcher for the trail sink; one clock domain, muted while in reset
module pts_trail_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic link_data,
    input wire logic link_fs,
    input wire logic server_signal_fail_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic data_out,
    input wire logic clk_out,
    input wire logic fs_out,
    input wire logic trail_signal_fail_out,
    input wire logic remote_defect_request,
    input wire logic [3:0] remote_error_request,
    input wire logic remote_error_valid
);
    logic [2:0] age_reg;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Age since reset, so delayed-copy checks never look back into reset
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            age_reg <= 3'h0;
        else if (age_reg != 3'h7)
            age_reg <= age_reg + 3'h1;
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad_addr;
        s_setup ##0 (paddr[7:6] != 2'h0 || paddr[1:0] != 2'h0);
    endsequence
    property p_apb_answer;
        s_setup |=> pready && psel && penable;
    endproperty
    property p_ready_in_access;
        pready |-> psel && penable;
    endproperty
    property p_refuse;
        s_bad_addr |=> pslverr && pready;
    endproperty
    property p_tsf_rdi;
        remote_defect_request == trail_signal_fail_out;
    endproperty
    property p_ssf_fail;
        server_signal_fail_in [*8] |-> trail_signal_fail_out;
    endproperty
    // Replacement may end one or two cycles ahead of the fail flag
    property p_ais;
        (!server_signal_fail_in) [*8] ##0 trail_signal_fail_out |-> data_out or ##[1:2] !trail_signal_fail_out;
    endproperty
    property p_pass;
        age_reg == 3'h7 && data_out != $past(link_data, 3) |-> ##[0:2] trail_signal_fail_out;
    endproperty
    property p_clk_fs;
        age_reg == 3'h7 |-> clk_out == $past(link_clk, 3) && fs_out == $past(link_fs, 3);
    endproperty
    property p_rei_pulse;
        remote_error_valid |=> !remote_error_valid;
    endproperty
    property p_rei_range;
        remote_error_valid |-> remote_error_request <= 4'h8;
    endproperty
    a_apb_answer: assert property (p_apb_answer)
        else $error("pready missing in access cycle");
    a_ready_in_access: assert property (p_ready_in_access)
        else $error("pready outside access cycle");
    a_refuse: assert property (p_refuse)
        else $error("unmapped address not refused");
    a_tsf_rdi: assert property (p_tsf_rdi)
        else $error("fail and remote defect request differ");
    a_ssf_fail: assert property (p_ssf_fail)
        else $error("server fail did not raise trail fail");
    a_ais: assert property (p_ais)
        else $error("data not all ones during replacement");
    a_pass: assert property (p_pass)
        else $error("data altered without a fail");
    a_clk_fs: assert property (p_clk_fs)
        else $error("clock or frame start not passed through");
    a_rei_pulse: assert property (p_rei_pulse)
        else $error("error count strobe longer than a cycle");
    a_rei_range: assert property (p_rei_range)
        else $error("parity difference count above eight");
endmodule : pts_trail_monitor
`default_nettype wire

// *** tb/pts_link_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Server layer: short frames, MSB first; the clock stands still until run
module pts_link_model #(
    parameter int FRAME_BYTES = 6
) (
    input wire logic run,
    input wire logic bad,
    input wire logic [7:0] ma,
    output logic link_clk,
    output logic link_data,
    output logic link_fs,
    output int frame_no
);
    logic [7:0] fr [FRAME_BYTES];
    logic [7:0] par;
    // One frame a pass; parity covers every byte of the frame before
    initial
    begin
        link_clk = 1'b0;
        link_data = 1'b0;
        link_fs = 1'b0;
        frame_no = 0;
        par = 8'h00;
        #1.3;
        forever
        begin
            if (run !== 1'b1)
            begin
                link_data = ~link_data; // Idle line never shows a stale value
                #48;
            end
            else
            begin
                fr[0] = 8'hf6;
                fr[1] = 8'h28;
                fr[2] = bad ? (par ^ 8'h05) : par;
                fr[3] = (frame_no % 16 == 0) ? 8'h80 : 8'(frame_no % 16);
                fr[4] = ma;
                fr[5] = 8'(frame_no);
                frame_no++;
                for (int i = 0; i < FRAME_BYTES * 8; i++)
                begin
                    link_data = fr[i / 8][7 - i % 8];
                    link_fs = (i == 0);
                    #24 link_clk = 1'b1;
                    #24 link_clk = 1'b0;
                end
                link_fs = 1'b0;
                par = 8'h00;
                foreach (fr[j])
                    par ^= fr[j];
            end
        end
    end
endmodule : pts_link_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ssf = 1'b0;
    logic eq = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic run = 1'b0;
    logic bad = 1'b0;
    logic [7:0] ma = 8'h18;
    wire logic link_clk, link_data, link_fs;
    logic [31:0] prdata, r;
    logic pready, pslverr, perr, data_out, clk_out, fs_out, tsf, tsd, rdr, rev, irq;
    logic [3:0] rer;
    int frame_no, n_fail = 0, num_checks = 0, rei_sum = 0;
    pts_trail_sink #(.ONE_SEC_CYCLES(3000)) DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .link_data(link_data), .link_fs(link_fs),
        .server_signal_fail_in(ssf), .equipment_defect(eq), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_out(data_out),
        .clk_out(clk_out), .fs_out(fs_out), .trail_signal_fail_out(tsf), .trail_signal_degrade_out(tsd),
        .remote_defect_request(rdr), .remote_error_request(rer), .remote_error_valid(rev), .irq(irq));
    pts_link_model LINK (.run(run), .bad(bad), .ma(ma), .link_clk(link_clk), .link_data(link_data),
        .link_fs(link_fs), .frame_no(frame_no));
    // 250 MHz system clock
    initial
        forever #2 ref_clk = ~ref_clk;
    // Sum of reported parity differences
    always @(posedge ref_clk)
        if (rev === 1'b1)
            rei_sum <= rei_sum + int'(rer);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One transfer; the request is held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rd
    task automatic frames(input int n);
        int k;
        k = frame_no + n;
        while (frame_no < k)
            @(posedge ref_clk);
    endtask : frames
    // Clears the one-second event, then polls until the next one
    task automatic tick();
        logic [31:0] q;
        wr(8'h0c, 32'h20);
        q = 32'h0;
        while (q[5] !== 1'b1)
            apb(1'b0, 8'h0c, 32'h0, q);
    endtask : tick
    task automatic ones_chk(input logic forced);
        int n;
        n = 0;
        repeat (300)
        begin
            @(posedge ref_clk);
            n += (data_out === 1'b1);
        end
        chk(n == 300, forced);
    endtask : ones_chk
    function automatic logic [31:0] tw(input int k);
        logic [31:0] w;
        w = 32'h0;
        for (int i = 3; i >= 0; i--)
            w = {w[23:0], (4 * k + i == 0) ? 8'h80 : 8'(4 * k + i)};
        return w;
    endfunction : tw
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // Bounded by a little more than the expected run
    initial
    begin
        #400us;
        n_fail++;
        wrap_up();
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0002_0010);
        rd(8'h40, 32'h0);
        chk(perr, 1'b1);
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08, 32'h0);
        for (int k = 0; k < 4; k++)
            wr(8'h20 + 8'(4 * k), tw(k));
        wr(8'h00, 32'h7);
        run <= 1'b1;
        frames(64);
        rd(8'h08, 32'h400);
        for (int k = 0; k < 4; k++)
            rd(8'h30 + 8'(4 * k), tw(k));
        wr(8'h2c, tw(3) ^ 32'h1);
        repeat (20) @(posedge ref_clk);
        rd(8'h08, 32'h442);
        chk({tsf, rdr}, 2'b11);
        ones_chk(1'b1);
        wr(8'h00, 32'hf);
        repeat (20) @(posedge ref_clk);
        rd(8'h08, 32'h400);
        ones_chk(1'b0);
        wr(8'h00, 32'h7);
        wr(8'h2c, tw(3));
        ma <= 8'h00;
        frames(7);
        rd(8'h08, 32'h421);
        ones_chk(1'b1);
        ma <= 8'h98;
        frames(7);
        rd(8'h08, 32'h508);
        chk(tsf, 1'b0);
        wr(8'h0c, 32'h3f);
        wr(8'h10, 32'h10);
        wr(8'h00, 32'h6);
        ssf <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rd(8'h08, 32'h418);
        chk({tsf, rdr, irq}, 3'b110);
        wr(8'h00, 32'h7);
        rd(8'h08, 32'h718);
        chk(irq, 1'b1);
        wr(8'h0c, 32'h10);
        repeat (3) @(posedge ref_clk);
        chk(irq, 1'b0);
        ssf <= 1'b0;
        ma <= 8'h18;
        wr(8'h10, 32'h0);
        frames(7);
        rd(8'h08, 32'h400);
        tick();
        bad <= 1'b1;
        ma <= 8'h58;
        frames(1);
        bad <= 1'b0;
        ma <= 8'h18;
        r = rei_sum;
        frames(2);
        chk(rei_sum - r, 32'h2);
        tick();
        rd(8'h14, 32'h1);
        rd(8'h18, 32'h1);
        rd(8'h1c, 32'h0);
        wr(8'h04, 32'h0001_0000);
        eq <= 1'b1;
        bad <= 1'b1;
        ma <= 8'h98;
        repeat (3) tick();
        chk(tsd, 1'b1);
        rd(8'h08, 32'h58c);
        rd(8'h1c, 32'h3);
        eq <= 1'b0;
        bad <= 1'b0;
        ma <= 8'h18;
        repeat (3) tick();
        chk(tsd, 1'b0);
        wrap_up();
    end
endmodule : testbench
bind pts_trail_sink pts_trail_monitor CHK (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk),
    .link_data(link_data), .link_fs(link_fs), .server_signal_fail_in(server_signal_fail_in), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .data_out(data_out), .clk_out(clk_out),
    .fs_out(fs_out), .trail_signal_fail_out(trail_signal_fail_out), .remote_defect_request(remote_defect_request),
    .remote_error_request(remote_error_request), .remote_error_valid(remote_error_valid));
`default_nettype wire
